// file: core/qt_pkg.sv
// constants for the query table information block
`default_nettype none
package qt_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int LOC_W  = 9;
    localparam int CNT_W  = 16;

    // register indices; byte address is four times the index
    localparam logic [LOC_W-1:0] LOC_CTRL      = 9'h000;
    localparam logic [LOC_W-1:0] LOC_STATUS    = 9'h001;
    localparam logic [LOC_W-1:0] LOC_OPT_FEAT  = 9'h112;
    localparam logic [LOC_W-1:0] LOC_VPP_OPT   = 9'h117;
    localparam logic [LOC_W-1:0] LOC_OTP_COUNT = 9'h118;
    localparam logic [LOC_W-1:0] LOC_DESC1     = 9'h119;
    localparam logic [LOC_W-1:0] LOC_DESC2     = 9'h11d;

    localparam logic [LOC_W-1:0] DESC1_BYTES = 9'h004;
    localparam logic [LOC_W-1:0] DESC2_BYTES = 9'h00a;

    // fixed query bytes
    localparam logic [7:0] VPP_OPT_VALUE    = 8'h90;
    localparam logic [7:0] OTP_COUNT_VALUE  = 8'h02;
    localparam logic [7:0] OPT_FEAT_NONE    = 8'h00;
    localparam logic [7:0] OPT_FEAT_STACK_1 = 8'h40;

    // lock byte 80 00, factory exp 03, user exp 03; low byte first
    localparam logic [31:0] DESC1_VALUE = 32'h0303_0080;
    // lock word 89 00 00 00, factory 00 00 00, user groups 10 00, exp 04
    localparam logic [79:0] DESC2_VALUE = 80'h0400_1000_0000_0000_0089;

    // control and status fields
    localparam int         CTRL_ON_BIT    = 0;
    localparam logic       CTRL_ON_RESET  = 1'b1;
    localparam int         STAT_STACK_BIT = 0;
    localparam int         STAT_DIE2_BIT  = 1;
    localparam int         STAT_CNT_LSB   = 16;
    localparam logic [1:0] ALIGN_OK       = 2'b00;

endpackage
`default_nettype wire

// file: core/qt_rom_if.sv
// carrier between the bus slave and the query byte lookup
`timescale 1ns/1ps
`default_nettype none
interface qt_rom_if;
    import qt_pkg::*;
    logic [LOC_W-1:0] loc;
    logic             stacked;
    logic             die2;
    logic             hit;
    logic [7:0]       data;

    modport slave (output loc, output stacked, output die2, input hit, input data);
    modport rom   (input loc, input stacked, input die2, output hit, output data);
endinterface
`default_nettype wire

// file: core/qt_rom.sv
// fixed query byte lookup for locations 112 and 117 to 126
`timescale 1ns/1ps
`default_nettype none
module qt_rom
    import qt_pkg::*;
(
    qt_rom_if.rom q
);

    logic [LOC_W-1:0] d1_off;
    logic [LOC_W-1:0] d2_off;
    logic             in_d1;
    logic             in_d2;
    logic [1:0]       d1_sel;
    logic [3:0]       d2_sel;
    logic [7:0]       opt_feat;

    assign d1_off = q.loc - LOC_DESC1;
    assign d2_off = q.loc - LOC_DESC2;
    assign in_d1  = (q.loc >= LOC_DESC1) && (d1_off < DESC1_BYTES);
    assign in_d2  = (q.loc >= LOC_DESC2) && (d2_off < DESC2_BYTES);
    // clamp keeps the part-select inside the constant when not hit
    assign d1_sel = in_d1 ? d1_off[1:0] : 2'h0;
    assign d2_sel = in_d2 ? d2_off[3:0] : 4'h0;

    // only die 1 of the stacked part reports the extra feature bit
    assign opt_feat = (q.stacked && !q.die2) ? OPT_FEAT_STACK_1 : OPT_FEAT_NONE;

    assign q.hit = (q.loc == LOC_OPT_FEAT) || (q.loc == LOC_VPP_OPT)
                || (q.loc == LOC_OTP_COUNT) || in_d1 || in_d2;

    assign q.data = (q.loc == LOC_OPT_FEAT)  ? opt_feat :
                    (q.loc == LOC_VPP_OPT)   ? VPP_OPT_VALUE :
                    (q.loc == LOC_OTP_COUNT) ? OTP_COUNT_VALUE :
                    in_d1 ? DESC1_VALUE[d1_sel*8 +: 8] :
                    in_d2 ? DESC2_VALUE[d2_sel*8 +: 8] :
                    8'h00;

endmodule
`default_nettype wire

// file: core/qt_query_table.sv
// apb slave serving the query table information bytes
// Notes on behaviour
// - location 117 reads 90: nine volts optimum program/erase supply
// - location 112 reads 40 on stacked die 1, else 00
// - location 118 reads 02 descriptors; zero would mean 256
// - first descriptor at 119: lock byte address 80 then 00
// - first descriptor bytes three and four read 03, eight bytes each
// - second descriptor at 11D: lock word address 89 00 00 00
// - factory group count and size exponent bytes read zero
// - user groups 10 00 then exponent 04
`timescale 1ns/1ps
`default_nettype none
module qt_query_table
    import qt_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [DATA_W-1:0]      prdata,
    output logic                   pslverr,
    input  wire logic              stacked_pin,
    input  wire logic              die2_pin
);

    ////////////////////////////////////////////////////////////////////
    // strap synchronisers

    logic [1:0] strap_meta;
    logic [1:0] strap_sync;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_meta <= 2'b00;
            strap_sync <= 2'b00;
        end else begin
            strap_meta <= {die2_pin, stacked_pin};
            strap_sync <= strap_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // decode

    qt_rom_if rif ();

    qt_rom u_rom (
        .q (rif.rom)
    );

    logic              ctrl_on;
    logic [CNT_W-1:0]  read_count;
    logic [ADDR_W-3:0] idx;
    logic              aligned;
    logic              in_range;
    logic              is_ctrl;
    logic              is_status;
    logic              is_rom;
    logic              setup;
    logic              access;
    logic              do_write;
    logic [DATA_W-1:0] next_rdata;
    logic              next_err;
    logic [DATA_W-1:0] ctrl_word;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] rom_word;

    assign idx      = paddr[ADDR_W-1:2];
    assign aligned  = (paddr[1:0] == ALIGN_OK);
    assign in_range = (idx[ADDR_W-3:LOC_W] == '0);
    assign rif.loc     = idx[LOC_W-1:0];
    assign rif.stacked = strap_sync[0];
    assign rif.die2    = strap_sync[1];

    assign is_ctrl   = aligned && in_range && (rif.loc == LOC_CTRL);
    assign is_status = aligned && in_range && (rif.loc == LOC_STATUS);
    assign is_rom    = aligned && in_range && rif.hit;

    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign do_write = access && pwrite && is_ctrl && pstrb[0];

    assign ctrl_word = {{(DATA_W-1){1'b0}}, ctrl_on};
    assign status_word = {read_count, {(STAT_CNT_LSB-2){1'b0}},
                          strap_sync[1], strap_sync[0]};
    // upper lanes held at zero; query off reads as zero
    assign rom_word = ctrl_on ? {{(DATA_W-8){1'b0}}, rif.data} : '0;

    assign next_rdata = pwrite    ? '0 :
                        is_ctrl   ? ctrl_word :
                        is_status ? status_word :
                        is_rom    ? rom_word : '0;
    // query bytes are read-only; writing them is an error
    assign next_err = !(is_ctrl || is_status || is_rom) || (pwrite && !is_ctrl);

    // zero wait states: answer latched at setup, shown in access
    assign pready = 1'b1;

    ////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= next_rdata;
            pslverr <= next_err;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_on <= CTRL_ON_RESET;
        end else if (do_write) begin
            ctrl_on <= pwdata[CTRL_ON_BIT];
        end
    end

    // saturating count of completed query reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_count <= '0;
        end else if (access && !pwrite && is_rom && (read_count != '1)) begin
            read_count <= read_count + 1'b1;
        end
    end

endmodule
`default_nettype wire

// file: verif/qt_query_table_properties.sv
// checker of query byte values seen at the apb ports
`timescale 1ns/1ps
`default_nettype none
module qt_query_table_chk
    import qt_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              pready,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pslverr,
    input wire logic              stacked_pin,
    input wire logic              die2_pin
);
    // shadow of the query enable, rebuilt from completed control writes
    logic query_on;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            query_on <= 1'b1;
        end else if (psel && penable && pready && pwrite && paddr == 12'h000 && pstrb[0]) begin
            query_on <= pwdata[0];
        end
    end
    // read data is loaded at the setup edge, so it is judged one cycle on
    wire s     = psel && !penable && !pwrite && query_on;
    wire s_off = psel && !penable && !pwrite && !query_on;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_supply_volts: assert property (s && paddr == 12'h45c |=> prdata == 32'h90)
        else $error("supply byte wrong");
    a_feature_die: assert property (s && paddr == 12'h448 |=>
        prdata == ((stacked_pin && !die2_pin) ? 32'h40 : 32'h0)) else $error("feature byte wrong");
    a_field_count: assert property (s && paddr == 12'h460 |=> prdata == 32'h2)
        else $error("field count wrong");
    a_lock_byte: assert property (s && paddr == 12'h464 |=> prdata == 32'h80)
        else $error("lock byte wrong");
    a_size_exp: assert property (s && paddr inside {12'h46c, 12'h470} |=> prdata == 32'h3)
        else $error("size exponent wrong");
    a_lock_word: assert property (s && paddr == 12'h474 |=> prdata == 32'h89)
        else $error("lock word wrong");
    a_factory_zero: assert property (s && paddr inside {[12'h484:12'h48c]} |=> !prdata)
        else $error("factory byte wrong");
    a_user_groups: assert property (s && paddr == 12'h490 |=> prdata == 32'h10)
        else $error("user groups wrong");
    a_upper_zero: assert property (s && paddr inside {[12'h448:12'h498]} |=> !prdata[31:8])
        else $error("upper bits set");
    a_query_off: assert property (s_off && paddr inside {[12'h448:12'h498]} |=> !prdata)
        else $error("query off not zero");
    a_write_refused: assert property (psel && !penable && pwrite &&
        paddr inside {[12'h448:12'h498]} |=> pslverr) else $error("query write accepted");
endmodule
bind qt_query_table qt_query_table_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .stacked_pin, .die2_pin);
`default_nettype wire

// file: verif/qt_host.sv
// apb host model reading the query table
`timescale 1ns/1ps
`default_nettype none
module qt_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    initial {psel, penable, pwrite, paddr, pwdata, pstrb} = {3'b0, 12'h0, 32'h0, 4'hf};
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
              output logic [31:0] rd, output logic err);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        // stale write data would hide a slave that samples it late
        {psel, penable, pwdata} <= {2'b0, ~wd};
    endtask
endmodule
`default_nettype wire

// file: verif/tb_qt_query_table.sv
// testbench for the query table apb slave
`timescale 1ns/1ps
`default_nettype none
module tb_qt_query_table;
    import qt_pkg::*;
    logic              pclk = 0, presetn = 0, stacked_pin = 0, die2_pin = 0, psel, penable;
    logic              pwrite, pready, pslverr, e;
    logic [3:0]        pstrb;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, d;
    int                num_errors = 0, total_checks = 0, cyc = 0;
    initial forever #4 pclk = ~pclk;
    always @(posedge pclk) if (++cyc == 4000) begin num_errors++; stop_test(); end
    qt_query_table dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .stacked_pin, .die2_pin);
    qt_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
        .pslverr);
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin num_errors++; $display("mismatch %0t got %h exp %h", $time, got, exp); end
    endtask
    task t_table;
        logic [7:0] x [16];
        x = '{8'h90, 8'h02, 8'h80, 8'h00, 8'h03, 8'h03, 8'h89, 8'h00, 8'h00, 8'h00, 8'h00,
              8'h00, 8'h00, 8'h10, 8'h00, 8'h04};
        for (int i = 0; i < 16; i++) begin
            host.xfer(1'b0, 12'h45c + 12'(4 * i), 32'h0, d, e);
            chk(d, {24'h0, x[i]});
            chk({31'h0, e}, 32'h0);
        end
    endtask
    task t_straps;
        for (int k = 0; k < 4; k++) begin
            {die2_pin, stacked_pin} <= 2'(k);
            // straps pass a two-flop synchroniser
            repeat (4) @(posedge pclk);
            host.xfer(1'b0, 12'h448, 32'h0, d, e);
            chk(d, (k == 1) ? 32'h40 : 32'h0);
        end
    endtask
    task t_refuse;
        host.xfer(1'b1, 12'h45c, 32'hff, d, e);
        chk({31'h0, e}, 32'h1);
        host.xfer(1'b0, 12'h45d, 32'h0, d, e);
        chk({31'h0, e}, 32'h1);
        host.xfer(1'b0, 12'h45c, 32'h0, d, e);
        chk(d, 32'h90);
    endtask
    task t_ctrl;
        // query off hides the bytes but raises no error
        host.xfer(1'b1, 12'h000, 32'h0, d, e);
        chk({31'h0, e}, 32'h0);
        host.xfer(1'b0, 12'h000, 32'h0, d, e);
        chk(d, 32'h0);
        host.xfer(1'b0, 12'h45c, 32'h0, d, e);
        chk(d, 32'h0);
        chk({31'h0, e}, 32'h0);
        host.xfer(1'b1, 12'h000, 32'h1, d, e);
        host.xfer(1'b0, 12'h000, 32'h0, d, e);
        chk(d, 32'h1);
        host.xfer(1'b0, 12'h45c, 32'h0, d, e);
        chk(d, 32'h90);
    endtask
    task t_status;
        host.xfer(1'b1, 12'h000, 32'h0, d, e);
        // reset in mid-run restores the enable and clears the count
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        host.xfer(1'b0, 12'h000, 32'h0, d, e);
        chk(d, 32'h1);
        host.xfer(1'b0, 12'h004, 32'h0, d, e);
        chk(d, {30'h0, die2_pin, stacked_pin});
        host.xfer(1'b0, 12'h45c, 32'h0, d, e);
        chk(d, 32'h90);
        // straps left as stacked die 2 by the strap scenario
        host.xfer(1'b0, 12'h448, 32'h0, d, e);
        chk(d, 32'h0);
        // refused accesses are not counted
        host.xfer(1'b0, 12'h449, 32'h0, d, e);
        chk({31'h0, e}, 32'h1);
        host.xfer(1'b1, 12'h448, 32'h0, d, e);
        chk({31'h0, e}, 32'h1);
        host.xfer(1'b0, 12'h004, 32'h0, d, e);
        chk(d, {16'h0002, 14'h0, die2_pin, stacked_pin});
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        t_table;
        t_straps;
        t_refuse;
        t_ctrl;
        t_status;
        stop_test;
    end
endmodule
`default_nettype wire
